// ==== inc/bridge_regs.vh ====
// register map, field positions, reset values and timing counts of the
// bridge clock-gate and error-cause bank; included by the bank itself.
`ifndef BRIDGE_REGS_VH
`define BRIDGE_REGS_VH

// ==========================================================
// register indices; byte address is four times the index
`define IDX_SEC_CLOCK_GATING 8'h68
`define IDX_PRIMARY_ERROR_CAUSE 8'h6A
`define IDX_POWER_CAP_ID 8'hDC
`define IDX_SERR_MASK 8'h70
`define IDX_IRQ_MASK 8'h71

// ==========================================================
// reset and constant values
`define RST_SEC_CLOCK_GATING 16'h0000
`define RST_PRIMARY_ERROR_CAUSE 8'h00
`define RST_SERR_MASK 8'h00
`define RST_IRQ_MASK 8'h00
`define VAL_POWER_CAP_ID 8'h01

// ==========================================================
// field layout
`define CLK_GATING_WRITABLE 16'h3FFF
`define ERR_CAUSE_WRITABLE 8'h7E
`define BIT_DR_TIMEOUT 6
`define BIT_DW_TIMEOUT 5
`define BIT_PW_MASTER_ABORT 4
`define BIT_PW_TARGET_ABORT 3
`define BIT_PW_TIMEOUT 2
`define BIT_PW_PARITY 1
`define POS_WIDE_GATES 8

// ==========================================================
// retry time-out: two to the twenty-fourth retries
`define RETRY_LIMIT_DEFAULT 25'h1000000

// ==========================================================
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/bridge_clock_gate_error_status.v ====
// register bank: secondary clock gating, error-cause capture with system
// error signalling, power-management capability identifier, AXI4-Lite slave.
// assumes one clock, error events from same-clock bridge logic as pulses.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_regs.vh"

module bridge_clock_gate_error_status #(
	parameter [24:0] RETRY_LIMIT = `RETRY_LIMIT_DEFAULT // retries before time-out
) (
	input wire aclk, // bank clock
	input wire aresetn, // synchronous reset, active low
	input wire clk_en, // freezes all state while low
	input wire [31:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write byte strobes
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [31:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire pw_parity_err, // posted write parity error pulse
	input wire pw_target_abort, // posted write target abort pulse
	input wire pw_master_abort, // posted write master abort pulse
	input wire pw_retry, // posted write retried pulse
	input wire pw_retry_done, // posted write completed, clears count
	input wire dw_retry, // delayed write retried pulse
	input wire dw_retry_done, // delayed write completed, clears count
	input wire dr_retry, // delayed read retried pulse
	input wire dr_retry_done, // delayed read completed, clears count
	output reg primary_system_error_out, // one-cycle system error pulse
	output reg irq, // level interrupt
	output wire sec_clk_out_0, // secondary clock 0
	output wire sec_clk_out_1, // secondary clock 1
	output wire sec_clk_out_2, // secondary clock 2
	output wire sec_clk_out_3, // secondary clock 3
	output wire sec_clk_out_4, // secondary clock 4
	output wire sec_clk_out_5, // secondary clock 5
	output wire sec_clk_out_6, // secondary clock 6
	output wire sec_clk_out_7, // secondary clock 7
	output wire sec_clk_out_8, // secondary clock 8
	output wire sec_clk_out_9 // secondary clock 9
);

	// ==========================================================
	// helpers
	function [7:0] merge_byte;
		input [7:0] old_val;
		input [7:0] new_val;
		input lane;
		begin
			merge_byte = lane ? new_val : old_val;
		end
	endfunction

	// registers sit on whole words; any other byte address misses
	function hits;
		input [31:0] addr;
		input [7:0] idx;
		begin
			hits = (addr == {22'h0, idx, 2'h0});
		end
	endfunction

	// stop mask per output from the gating register
	function [9:0] clock_stops;
		input [15:0] ctl;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				clock_stops[k] = ctl[2 * k] & ctl[2 * k + 1];
			end
			clock_stops[9:4] = ctl[13:8];
		end
	endfunction

	function [24:0] next_retry;
		input [24:0] cnt;
		begin
			next_retry = cnt + 25'h0000001;
		end
	endfunction

	// ==========================================================
	// registers
	reg [15:0] sec_clock_gating;
	reg [7:0] primary_error_cause;
	reg [7:0] serr_mask;
	reg [7:0] irq_mask;
	reg [24:0] pw_retry_cnt;
	reg [24:0] dw_retry_cnt;
	reg [24:0] dr_retry_cnt;
	reg clk_phase;
	reg [9:0] sec_clk;

	// write channel holding state
	reg aw_full;
	reg w_full;
	reg [31:0] wr_addr;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_commit = aw_full & w_full & ~s_axi_bvalid;
	wire ar_take = s_axi_arvalid & s_axi_arready;

	wire wr_clk = hits(wr_addr, `IDX_SEC_CLOCK_GATING);
	wire wr_cause = hits(wr_addr, `IDX_PRIMARY_ERROR_CAUSE);
	wire wr_cap = hits(wr_addr, `IDX_POWER_CAP_ID);
	wire wr_smask = hits(wr_addr, `IDX_SERR_MASK);
	wire wr_imask = hits(wr_addr, `IDX_IRQ_MASK);
	wire wr_mapped = wr_clk | wr_cause | wr_cap | wr_smask | wr_imask;

	// ==========================================================
	// error events and retry time-outs
	wire pw_timeout = pw_retry & (next_retry(pw_retry_cnt) == RETRY_LIMIT);
	wire dw_timeout = dw_retry & (next_retry(dw_retry_cnt) == RETRY_LIMIT);
	wire dr_timeout = dr_retry & (next_retry(dr_retry_cnt) == RETRY_LIMIT);

	reg [7:0] raw_events;
	always @* begin
		raw_events = 8'h00;
		raw_events[`BIT_DR_TIMEOUT] = dr_timeout;
		raw_events[`BIT_DW_TIMEOUT] = dw_timeout;
		raw_events[`BIT_PW_MASTER_ABORT] = pw_master_abort;
		raw_events[`BIT_PW_TARGET_ABORT] = pw_target_abort;
		raw_events[`BIT_PW_TIMEOUT] = pw_timeout;
		raw_events[`BIT_PW_PARITY] = pw_parity_err;
	end

	// only unmasked causes signal and get recorded
	wire [7:0] signalled = raw_events & ~serr_mask & `ERR_CAUSE_WRITABLE;

	// write-one-to-clear; a same-cycle event wins over the clear
	wire [7:0] cause_clear = (wr_commit & wr_cause & wr_strb[0]) ? wr_data[7:0] : 8'h00;
	wire [7:0] next_cause = ((primary_error_cause & ~cause_clear) | signalled)
		& `ERR_CAUSE_WRITABLE;

	// ==========================================================
	// retry counters
	// one bit wider than the limit so two to the twenty-fourth fits
	// a completed transfer clears its count, so time-outs need unbroken retries
	always @(posedge aclk) begin
		if (!aresetn) begin
			pw_retry_cnt <= 25'h0000000;
			dw_retry_cnt <= 25'h0000000;
			dr_retry_cnt <= 25'h0000000;
		end else if (clk_en) begin
			if (pw_retry_done || pw_timeout) begin
				pw_retry_cnt <= 25'h0000000;
			end else if (pw_retry) begin
				pw_retry_cnt <= next_retry(pw_retry_cnt);
			end
			if (dw_retry_done || dw_timeout) begin
				dw_retry_cnt <= 25'h0000000;
			end else if (dw_retry) begin
				dw_retry_cnt <= next_retry(dw_retry_cnt);
			end
			if (dr_retry_done || dr_timeout) begin
				dr_retry_cnt <= 25'h0000000;
			end else if (dr_retry) begin
				dr_retry_cnt <= next_retry(dr_retry_cnt);
			end
		end
	end

	// ==========================================================
	// status, masks, system error and interrupt
	// masks keep only the six cause bits; reserved bits stay zero
	always @(posedge aclk) begin
		if (!aresetn) begin
			primary_error_cause <= `RST_PRIMARY_ERROR_CAUSE;
			serr_mask <= `RST_SERR_MASK;
			irq_mask <= `RST_IRQ_MASK;
			primary_system_error_out <= 1'b0;
			irq <= 1'b0;
		end else if (clk_en) begin
			primary_error_cause <= next_cause;
			primary_system_error_out <= |signalled;
			irq <= |(next_cause & irq_mask);
			if (wr_commit && wr_smask && wr_strb[0]) begin
				serr_mask <= wr_data[7:0] & `ERR_CAUSE_WRITABLE;
			end
			if (wr_commit && wr_imask && wr_strb[0]) begin
				irq_mask <= wr_data[7:0] & `ERR_CAUSE_WRITABLE;
			end
		end
	end

	// ==========================================================
	// clock gating register and secondary clocks
	wire [15:0] next_gating = {merge_byte(sec_clock_gating[15:8], wr_data[15:8], wr_strb[1]),
		merge_byte(sec_clock_gating[7:0], wr_data[7:0], wr_strb[0])} & `CLK_GATING_WRITABLE;
	wire [9:0] stops = clock_stops(sec_clock_gating);

	always @(posedge aclk) begin
		if (!aresetn) begin
			sec_clock_gating <= `RST_SEC_CLOCK_GATING;
			clk_phase <= 1'b0;
			sec_clk <= 10'h000;
		end else if (clk_en) begin
			if (wr_commit && wr_clk) begin
				sec_clock_gating <= next_gating;
			end
			clk_phase <= ~clk_phase;
			// stopped outputs sit high, running ones follow aclk / 2
			// a gate change acts at one edge, so no pulse is shorter than a cycle
			sec_clk <= stops | {10{~clk_phase}};
		end
	end

	assign sec_clk_out_0 = sec_clk[0];
	assign sec_clk_out_1 = sec_clk[1];
	assign sec_clk_out_2 = sec_clk[2];
	assign sec_clk_out_3 = sec_clk[3];
	assign sec_clk_out_4 = sec_clk[4];
	assign sec_clk_out_5 = sec_clk[5];
	assign sec_clk_out_6 = sec_clk[6];
	assign sec_clk_out_7 = sec_clk[7];
	assign sec_clk_out_8 = sec_clk[8];
	assign sec_clk_out_9 = sec_clk[9];

	// ==========================================================
	// write channel
	// address and data may arrive in either order; commit waits for both
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_addr <= 32'h00000000;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (!aw_full && !s_axi_bvalid) begin
				s_axi_awready <= ~aw_take;
			end
			if (!w_full && !s_axi_bvalid) begin
				s_axi_wready <= ~w_take;
			end
			if (aw_take) begin
				aw_full <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_full <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_commit) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_bresp <= `RESP_OKAY;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// read channel
	// read data captured at the address handshake, held until taken
	reg [31:0] rd_word;
	reg rd_mapped;
	always @* begin
		rd_word = 32'h00000000;
		rd_mapped = 1'b1;
		if (hits(s_axi_araddr, `IDX_SEC_CLOCK_GATING)) begin
			rd_word = {16'h0000, sec_clock_gating & `CLK_GATING_WRITABLE};
		end else if (hits(s_axi_araddr, `IDX_PRIMARY_ERROR_CAUSE)) begin
			rd_word = {24'h000000, primary_error_cause & `ERR_CAUSE_WRITABLE};
		end else if (hits(s_axi_araddr, `IDX_POWER_CAP_ID)) begin
			rd_word = {24'h000000, `VAL_POWER_CAP_ID};
		end else if (hits(s_axi_araddr, `IDX_SERR_MASK)) begin
			rd_word = {24'h000000, serr_mask};
		end else if (hits(s_axi_araddr, `IDX_IRQ_MASK)) begin
			rd_word = {24'h000000, irq_mask};
		end else begin
			rd_mapped = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (ar_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RESP_OKAY;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // bridge_clock_gate_error_status

`default_nettype wire

// ==== sim/bridge_clock_gate_error_status_assertions.sv ====
// checker: bus timing, read values, stopped clock level of the bank
// assumes clk_en held high; bound to the bank top by port name
`timescale 1ns/1ps
`default_nettype none
module bcg_checker (
	input wire aclk, // clock
	input wire aresetn, // reset
	input wire [31:0] s_axi_awaddr, // aw addr
	input wire s_axi_awvalid, // aw valid
	input wire s_axi_awready, // aw ready
	input wire s_axi_wvalid, // w valid
	input wire s_axi_wready, // w ready
	input wire [1:0] s_axi_bresp, // b resp
	input wire s_axi_bvalid, // b valid
	input wire [31:0] s_axi_araddr, // ar addr
	input wire s_axi_arvalid, // ar valid
	input wire s_axi_arready, // ar ready
	input wire [31:0] s_axi_rdata, // r data
	input wire s_axi_rvalid, // r valid
	input wire s_axi_rready, // r ready
	input wire pw_parity_err, // event
	input wire pw_target_abort, // event
	input wire pw_master_abort, // event
	input wire pw_retry, // event
	input wire dw_retry, // event
	input wire dr_retry, // event
	input wire primary_system_error_out, // error out
	input wire sec_clk_out_0, // clock 0
	input wire sec_clk_out_9 // clock 9
);
wire any_ev = pw_parity_err | pw_target_abort | pw_master_abort | pw_retry | dw_retry | dr_retry;
// ========
// checks
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence s_wr;
	s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence s_rd(a);
	s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
endsequence
AST_WR_RESP: assert property (s_wr |=> !s_axi_awready ##1 s_axi_bvalid && !s_axi_awready)
	else $error("write response missing");
AST_UNMAPPED: assert property (s_wr ##0 (s_axi_awaddr == 32'h10) |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2)
	else $error("unmapped write not refused");
AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
	else $error("read answer late");
AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read data not held");
AST_GATE_RSV: assert property (s_rd(32'h1A0) |=> s_axi_rdata[31:14] == 18'h0)
	else $error("gating top bits not zero");
AST_CAUSE_RSV: assert property (s_rd(32'h1A8) |=> s_axi_rdata[31:7] == 25'h0 && !s_axi_rdata[0])
	else $error("cause reserved bits not zero");
AST_CAP_ID: assert property (s_rd(32'h370) |=> s_axi_rdata == 32'h1)
	else $error("capability id wrong");
AST_ERR_CAUSE: assert property (primary_system_error_out |-> $past(any_ev))
	else $error("error out without event");
AST_CLK0_HIGH: assert property (!sec_clk_out_0 |=> sec_clk_out_0)
	else $error("clock 0 held low");
AST_CLK9_HIGH: assert property (!sec_clk_out_9 |=> sec_clk_out_9)
	else $error("clock 9 held low");
endmodule // bcg_checker
bind bridge_clock_gate_error_status bcg_checker u_chk (.*);
`default_nettype wire

// ==== sim/sec_clk_sink.sv ====
// secondary bus clock receiver: flags a clock parked high
// assumes the bank clock samples it
`timescale 1ns/1ps
`default_nettype none
module sec_clk_sink (
	input wire logic aclk, // bank clock
	input wire logic aresetn, // reset, active low
	input wire logic clk_in, // received clock
	output logic held_high // parked high
);
logic [1:0] hi_cnt;
always @(posedge aclk) begin
	if (!aresetn || !clk_in)
		hi_cnt <= 2'h0;
	else if (hi_cnt != 2'h3)
		hi_cnt <= hi_cnt + 2'h1;
end
assign held_high = hi_cnt == 2'h3;
endmodule // sec_clk_sink
`default_nettype wire

// ==== sim/bridge_clock_gate_error_status_tb.sv ====
// bench for the clock-gate and error-cause bank
// drives AXI4-Lite and error pulses; sinks watch the ten clocks
`timescale 1ns/1ps
`default_nettype none
module bridge_clock_gate_error_status_tb;
localparam RL = 4;
logic aclk, aresetn = 0, clk_en = 1;
logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
logic [3:0] s_axi_wstrb = 4'hF;
logic [8:0] ev = 0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire primary_system_error_out, irq;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [9:0] sc, held;
logic [33:0] exp_q[$];
logic [1:0] wexp_q[$];
integer failures = 0, cmp_count = 0, seed = 77, i, j;
logic [15:0] v;
bridge_clock_gate_error_status #(.RETRY_LIMIT(25'h4)) uut (.*,
	.pw_parity_err(ev[0]), .pw_retry(ev[1]), .pw_target_abort(ev[2]),
	.pw_master_abort(ev[3]), .dw_retry(ev[4]), .dr_retry(ev[5]),
	.pw_retry_done(ev[6]), .dw_retry_done(ev[7]), .dr_retry_done(ev[8]),
	.sec_clk_out_0(sc[0]), .sec_clk_out_1(sc[1]), .sec_clk_out_2(sc[2]),
	.sec_clk_out_3(sc[3]), .sec_clk_out_4(sc[4]), .sec_clk_out_5(sc[5]),
	.sec_clk_out_6(sc[6]), .sec_clk_out_7(sc[7]), .sec_clk_out_8(sc[8]),
	.sec_clk_out_9(sc[9]));
for (genvar g = 0; g < 10; g++) begin : g_sink
	sec_clk_sink u_s (.aclk(aclk), .aresetn(aresetn), .clk_in(sc[g]), .held_high(held[g]));
end
initial begin
	aclk = 0;
	forever #5 aclk = ~aclk;
end
// ========
// tasks
task chk(input [33:0] seen, input [33:0] exp);
	cmp_count++;
	if (seen !== exp) begin
		failures++;
		$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task final_report;
	$display("compares %0d, mismatches %0d", cmp_count, failures);
	if (failures == 0 && cmp_count > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
task wr(input [31:0] a, input [31:0] d, input [1:0] r = 2'h0);
	reg b;
	@(posedge aclk);
	wexp_q.push_back(r);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1;
	s_axi_wvalid <= 1;
	s_axi_bready <= 1;
	b = 0;
	while (!b) begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 0;
		if (s_axi_wready) s_axi_wvalid <= 0;
		if (s_axi_bvalid) begin
			b = 1;
			s_axi_bready <= 0;
		end
	end
endtask
task rd(input [31:0] a, input [33:0] e, input integer w = 0);
	reg d;
	@(posedge aclk);
	exp_q.push_back(e);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1;
	s_axi_rready <= w == 0;
	d = 0;
	while (!d) begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 0;
		if (s_axi_rvalid && s_axi_rready) begin
			d = 1;
			s_axi_rready <= 0;
		end else if (s_axi_rvalid) begin
			w = w - 1;
			if (w <= 0) s_axi_rready <= 1;
		end
	end
endtask
task fire(input integer n, input integer b, input logic m);
	integer c;
	for (c = 0; c < n; c++) begin
		ev[b] <= 1;
		@(posedge aclk);
		ev[b] <= 0;
		@(posedge aclk);
		chk(primary_system_error_out, c == n - 1 && !m);
	end
endtask
function automatic [9:0] stop_of(input [15:0] g);
	for (int f = 0; f < 4; f++) stop_of[f] = &g[2 * f +: 2];
	stop_of[9:4] = g[13:8];
endfunction
always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
always @(posedge aclk) if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, wexp_q.pop_front());
// ========
// tests
initial begin
	repeat (3) @(posedge aclk);
	aresetn <= 1;
	repeat (2) @(posedge aclk);
	rd(32'h1A0, 34'h0);
	rd(32'h1A8, 34'h0);
	rd(32'h370, 34'h1);
	rd(32'h10, 34'h200000000);
	wr(32'h10, 32'hFFFFFFFF, 2'h2);
	wr(32'h370, 32'hFF);
	rd(32'h370, 34'h1, 2);
	$display("test reset values done");
	for (j = 0; j < 8; j++) begin
		v = j == 0 ? 16'hFFFF : j == 1 ? 16'h00AA : 16'($random(seed));
		wr(32'h1A0, {16'h0, v});
		rd(32'h1A0, {20'h0, v[13:0]});
		repeat (5) @(posedge aclk);
		chk(held, stop_of(v));
	end
	$display("test clock gating done");
	for (i = 0; i < 6; i++) begin
		fire(i == 1 || i > 3 ? RL : 1, i, 0);
		rd(32'h1A8, 34'h1 << (i + 1));
		wr(32'h1A8, 32'h0);
		rd(32'h1A8, 34'h1 << (i + 1));
		wr(32'h1A8, 32'h1 << (i + 1));
		rd(32'h1A8, 34'h0);
	end
	wr(32'h1C0, 32'h2);
	fire(1, 0, 1);
	rd(32'h1A8, 34'h0);
	wr(32'h1C0, 32'h0);
	$display("test error causes done");
	fire(1, 2, 0);
	for (j = 0; j < 4; j++) begin
		wr(j == 3 ? 32'h1A8 : 32'h1C4, j == 1 ? 32'h0 : 32'h8);
		repeat (2) @(posedge aclk);
		chk(irq, j == 0 || j == 2);
	end
	$display("test interrupt done");
	repeat (3) @(posedge aclk);
	final_report;
end
initial begin
	#100000;
	failures++;
	final_report;
end
endmodule // bridge_clock_gate_error_status_tb
`default_nettype wire
